// file: adc_startup_pkg.sv
package adc_startup_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 10;

  // timing, least times rounded up to whole cycles
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CAL_TIME_NS = 2000;
  localparam int OSC_CAL_CYCLES = (OSC_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_TIME_NS = 500;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FG_CAL_TIME_NS = 10000;
  localparam int FG_CAL_CYCLES = (FG_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PLL_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PLL_DIV = 8'h0c;
  localparam logic [7:0] ADDR_LINK_CTRL = 8'h10;
  localparam logic [7:0] ADDR_KM1 = 8'h14;
  localparam logic [7:0] ADDR_CAL_CTRL = 8'h18;
  localparam logic [7:0] ADDR_CAL_CFG = 8'h1c;
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h20;

  // ctrl fields
  localparam int CTRL_SOFT_RESET_BIT = 0;
  // status fields
  localparam int ST_INIT_DONE_BIT = 0;
  localparam int ST_OSC_CAL_DONE_BIT = 1;
  localparam int ST_PLL_LOCKED_BIT = 2;
  localparam int ST_FOREGROUND_CAL_DONE_BIT = 3;
  localparam int ST_CAL_BUSY_BIT = 4;
  localparam int ST_PLL_STRAP_BIT = 5;
  localparam int ST_REF_SEL_BIT = 6;
  localparam int ST_DATA_VALID_BIT = 7;
  // pll ctrl fields
  localparam int PLL_RESET_BIT = 0;
  localparam int PLL_OSC_CAL_EN_BIT = 1;
  localparam int PLL_BIAS_LSB = 8;
  localparam int PLL_TRIM_LSB = 16;
  // pll divider fields
  localparam int DIV_P_LSB = 0;
  localparam int DIV_V_LSB = 4;
  localparam int DIV_N_LSB = 8;
  // link ctrl fields
  localparam int LINK_EN_BIT = 0;
  localparam int LINK_MODE_LSB = 4;
  localparam int LINK_SYNC_SEL_BIT = 12;
  // cal ctrl fields
  localparam int CAL_EN_BIT = 0;
  localparam int CALIBRATION_SOFTWARE_TRIGGER_BIT = 1;
  localparam int CAL_PIN_TRIG_EN_BIT = 2;
  localparam int CAL_STATUS_SEL_BIT = 3;
  localparam int CAL_OVERRANGE_ENABLE_BIT = 4;
  // cal cfg fields
  localparam int CFG_A_LSB = 0;
  localparam int CFG_B_LSB = 8;

  // reset values
  localparam logic PLL_RESET_RST = 1'b1;
  localparam logic [7:0] BIAS_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [3:0] DIV_P_RST = 4'h2;
  localparam logic [3:0] DIV_V_RST = 4'h4;
  localparam logic [7:0] DIV_N_RST = 8'h0a;
  localparam logic LINK_EN_RST = 1'b1;
  localparam logic [4:0] LINK_MODE_RST = 5'h00;
  localparam logic [7:0] KM1_RST = 8'h1f;
  localparam logic CAL_EN_RST = 1'b1;
  localparam logic SOFT_TRIG_RST = 1'b1;
  localparam logic [7:0] CFG_A_RST = 8'h01;
  localparam logic [7:0] CFG_B_RST = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
  localparam int TRIG_OUT_EN_BIT = 7;

  // link modes at or above this index use 64b/66b
  localparam logic [4:0] LINK_MODE_64B_MIN = 5'h08;

  typedef enum {PLL_IN_RESET, PLL_CALIBRATING, PLL_LOCKING, PLL_LOCKED} pll_state_t;

endpackage

// file: adc_startup_sequence.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// R1: host ties pll and reference straps
// R2: host holds powerdown low when clocks needed
// R3: host issues software reset after power-up
// R4: host supplies stable clock on chosen input
// R5: device flags init done; host polls it
// R6: host resets pll, sets bias, dividers
// R7: host picks auto or manual trim, releases
// R8: pll strap low skips pll programming
// R9: link disabled before link settings change
// R10: calibration disabled before calibration changes
// R11: host sets link mode then multiframe length
// R12: host selects sync request source
// R13: host configures calibration while engine halted
// R14: trigger output configured before engines restart
// R15: device reports oscillator cal and lock
// R16: host enables calibration, overrange, then link
// R17: foreground cal on soft or pin rise
// R18: status pin and done bit mark finish
// R19: 8b/10b link follows sync; 64b/66b ignores
// R20: data valid needs link alignment and calibration
// R21: host bounds every poll with timeout
module adc_startup_sequence #(
  parameter int INIT_CYC = adc_startup_pkg::INIT_CYCLES,
  parameter int OSC_CYC = adc_startup_pkg::OSC_CAL_CYCLES,
  parameter int LOCK_CYC = adc_startup_pkg::LOCK_CYCLES,
  parameter int CAL_CYC = adc_startup_pkg::FG_CAL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [adc_startup_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_startup_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [adc_startup_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pll_enable_strap,
  input wire logic ref_clock_select_strap,
  input wire logic powerdown_pin,
  input wire logic calibration_trigger_pin,
  input wire logic single_ended_sync_input,
  input wire logic timestamp_input_pair,
  input wire logic rx_header_lock,
  output logic calibration_status_pin,
  output logic link_cgs_active,
  output logic link_data_active,
  output logic clock_outputs_enable,
  output logic trigger_clock_output_enable,
  output logic overrange_enable,
  output logic sample_data_valid
);
  import adc_startup_pkg::*;

  logic [6:0] pins_raw;
  logic [6:0] pins_s;
  logic pll_en_s;
  logic ref_sel_s;
  logic pd_s;
  logic trig_pin_s;
  logic se_sync_s;
  logic ts_sync_s;
  logic hdr_lock_s;
  logic sw_rst_q;
  logic cfg_rst;
  logic [CNT_W-1:0] init_cnt_q;
  logic init_done_q;
  logic pll_strap_q;
  logic ref_sel_q;
  logic wr;
  logic converter_pll_reset_q;
  logic oscillator_cal_enable_q;
  logic [7:0] oscillator_bias_field_q;
  logic [7:0] oscillator_freq_trim_q;
  logic [3:0] div_p_q;
  logic [3:0] div_v_q;
  logic [7:0] div_n_q;
  logic link_enable_q;
  logic [4:0] link_mode_select_q;
  logic sync_sel_q;
  logic [7:0] multiframe_length_minus_one_q;
  logic cal_enable_q;
  logic calibration_software_trigger_q;
  logic calibration_pin_trigger_enable_q;
  logic cal_status_sel_q;
  logic overrange_enable_q;
  logic [7:0] calibration_config_a_q;
  logic [7:0] calibration_config_b_q;
  logic [7:0] trigger_output_control_q;
  logic soft_rise;
  logic trig_pin_prev_q;
  logic pin_rise;
  pll_state_t pll_state_q;
  logic [CNT_W-1:0] pll_cnt_q;
  logic oscillator_cal_done;
  logic converter_pll_locked;
  logic is_64b;
  logic sync_req;
  logic rx_aligned;
  logic cal_ok;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rdata_q;
  cal_if cal ();

  if (INIT_CYC < 9 || INIT_CYC > 65535 || OSC_CYC < 1 || OSC_CYC > 65535 ||
      LOCK_CYC < 1 || LOCK_CYC > 65535) begin : g_chk
    $error("startup cycle counts out of range");
  end

  assign pins_raw = {rx_header_lock, timestamp_input_pair, single_ended_sync_input,
                     calibration_trigger_pin, powerdown_pin, ref_clock_select_strap,
                     pll_enable_strap};

  pin_sync #(.WIDTH(7)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pins(pins_raw),
    .pins_s(pins_s)
  );

  assign pll_en_s = pins_s[0];
  assign ref_sel_s = pins_s[1];
  assign pd_s = pins_s[2];
  assign trig_pin_s = pins_s[3];
  assign se_sync_s = pins_s[4];
  assign ts_sync_s = pins_s[5];
  assign hdr_lock_s = pins_s[6];

  // software reset pulse
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= reg_write && reg_addr == ADDR_CTRL && reg_wdata[CTRL_SOFT_RESET_BIT];
    end
  end

  assign cfg_rst = !rstn || sw_rst_q;

  // R5: internal init timer
  always_ff @(posedge sys_clk) begin
    if (cfg_rst) begin
      init_cnt_q <= '0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      if (init_cnt_q == CNT_W'(INIT_CYC - 1)) begin
        init_done_q <= 1'b1;
      end else begin
        init_cnt_q <= init_cnt_q + 1'b1;
      end
    end
  end

  // R1: straps captured during init
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pll_strap_q <= 1'b0;
      ref_sel_q <= 1'b0;
    end else if (!init_done_q) begin
      pll_strap_q <= pll_en_s;
      ref_sel_q <= ref_sel_s && pll_en_s;
    end
  end

  // writes other than the soft reset accepted only once init is done
  assign wr = reg_write && init_done_q;

  // R6: pll control and dividers
  always_ff @(posedge sys_clk) begin
    if (cfg_rst) begin
      converter_pll_reset_q <= PLL_RESET_RST;
      oscillator_cal_enable_q <= 1'b0;
      oscillator_bias_field_q <= BIAS_RST;
      oscillator_freq_trim_q <= TRIM_RST;
      div_p_q <= DIV_P_RST;
      div_v_q <= DIV_V_RST;
      div_n_q <= DIV_N_RST;
    end else if (wr && reg_addr == ADDR_PLL_CTRL) begin
      converter_pll_reset_q <= reg_wdata[PLL_RESET_BIT];
      oscillator_cal_enable_q <= reg_wdata[PLL_OSC_CAL_EN_BIT];
      oscillator_bias_field_q <= reg_wdata[PLL_BIAS_LSB +: 8];
      oscillator_freq_trim_q <= reg_wdata[PLL_TRIM_LSB +: 8];
    end else if (wr && reg_addr == ADDR_PLL_DIV) begin
      div_p_q <= reg_wdata[DIV_P_LSB +: 4];
      div_v_q <= reg_wdata[DIV_V_LSB +: 4];
      div_n_q <= reg_wdata[DIV_N_LSB +: 8];
    end
  end

  // R9: link settings frozen while link runs
  always_ff @(posedge sys_clk) begin
    if (cfg_rst) begin
      link_enable_q <= LINK_EN_RST;
      link_mode_select_q <= LINK_MODE_RST;
      sync_sel_q <= 1'b0;
      multiframe_length_minus_one_q <= KM1_RST;
      trigger_output_control_q <= TRIG_CTRL_RST;
    end else if (wr && reg_addr == ADDR_LINK_CTRL) begin
      link_enable_q <= reg_wdata[LINK_EN_BIT];
      if (!link_enable_q) begin
        link_mode_select_q <= reg_wdata[LINK_MODE_LSB +: 5];
        sync_sel_q <= reg_wdata[LINK_SYNC_SEL_BIT];
      end
    end else if (wr && reg_addr == ADDR_KM1 && !link_enable_q) begin
      multiframe_length_minus_one_q <= reg_wdata[7:0];
    end else if (wr && reg_addr == ADDR_TRIG_CTRL && !link_enable_q) begin
      trigger_output_control_q <= reg_wdata[7:0];
    end
  end

  // R10: calibration config frozen while engine enabled
  always_ff @(posedge sys_clk) begin
    if (cfg_rst) begin
      cal_enable_q <= CAL_EN_RST;
      calibration_software_trigger_q <= SOFT_TRIG_RST;
      calibration_pin_trigger_enable_q <= 1'b0;
      cal_status_sel_q <= 1'b0;
      overrange_enable_q <= 1'b0;
      calibration_config_a_q <= CFG_A_RST;
      calibration_config_b_q <= CFG_B_RST;
    end else if (wr && reg_addr == ADDR_CAL_CTRL) begin
      cal_enable_q <= reg_wdata[CAL_EN_BIT];
      calibration_software_trigger_q <= reg_wdata[CALIBRATION_SOFTWARE_TRIGGER_BIT];
      calibration_pin_trigger_enable_q <= reg_wdata[CAL_PIN_TRIG_EN_BIT];
      cal_status_sel_q <= reg_wdata[CAL_STATUS_SEL_BIT];
      overrange_enable_q <= reg_wdata[CAL_OVERRANGE_ENABLE_BIT];
    end else if (wr && reg_addr == ADDR_CAL_CFG && !cal_enable_q) begin
      calibration_config_a_q <= reg_wdata[CFG_A_LSB +: 8];
      calibration_config_b_q <= reg_wdata[CFG_B_LSB +: 8];
    end
  end

  // R17: trigger on soft bit or pin rising
  assign soft_rise = wr && reg_addr == ADDR_CAL_CTRL && reg_wdata[CALIBRATION_SOFTWARE_TRIGGER_BIT] &&
                     !calibration_software_trigger_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trig_pin_prev_q <= 1'b0;
    end else begin
      trig_pin_prev_q <= trig_pin_s;
    end
  end

  assign pin_rise = calibration_pin_trigger_enable_q && trig_pin_s && !trig_pin_prev_q;
  assign cal.start = cal_enable_q && (soft_rise || pin_rise);

  cal_engine #(.CAL_CYC(CAL_CYC)) u_cal (
    .sys_clk(sys_clk),
    .cfg_rstn(!cfg_rst),
    .cal(cal)
  );

  // R15: oscillator calibration and lock sequence
  always_ff @(posedge sys_clk) begin
    if (cfg_rst) begin
      pll_state_q <= PLL_IN_RESET;
      pll_cnt_q <= '0;
    end else begin
      case (pll_state_q)
        PLL_IN_RESET: begin
          pll_cnt_q <= '0;
          // R8: bypassed pll never leaves reset
          if (!converter_pll_reset_q && pll_strap_q && init_done_q) begin
            pll_state_q <= oscillator_cal_enable_q ? PLL_CALIBRATING : PLL_LOCKING;
          end
        end
        PLL_CALIBRATING: begin
          if (converter_pll_reset_q) begin
            pll_state_q <= PLL_IN_RESET;
          end else if (pll_cnt_q == CNT_W'(OSC_CYC - 1)) begin
            pll_state_q <= PLL_LOCKING;
            pll_cnt_q <= '0;
          end else begin
            pll_cnt_q <= pll_cnt_q + 1'b1;
          end
        end
        PLL_LOCKING: begin
          if (converter_pll_reset_q) begin
            pll_state_q <= PLL_IN_RESET;
          end else if (pll_cnt_q == CNT_W'(LOCK_CYC - 1)) begin
            pll_state_q <= PLL_LOCKED;
            pll_cnt_q <= '0;
          end else begin
            pll_cnt_q <= pll_cnt_q + 1'b1;
          end
        end
        PLL_LOCKED: begin
          if (converter_pll_reset_q) begin
            pll_state_q <= PLL_IN_RESET;
          end
        end
        default: begin
          pll_state_q <= PLL_IN_RESET;
        end
      endcase
    end
  end

  assign oscillator_cal_done = pll_state_q == PLL_LOCKING || pll_state_q == PLL_LOCKED;
  assign converter_pll_locked = pll_state_q == PLL_LOCKED;

  // R19: mode decides whether sync is used
  assign is_64b = link_mode_select_q >= LINK_MODE_64B_MIN;
  // R12: sync source select
  assign sync_req = sync_sel_q ? ts_sync_s : se_sync_s;
  assign rx_aligned = is_64b ? hdr_lock_s : sync_req;
  // R18: status pin or done bit per select
  assign cal_ok = cal_status_sel_q ? cal.done : calibration_status_pin;

  always_ff @(posedge sys_clk) begin
    if (cfg_rst) begin
      link_cgs_active <= 1'b0;
      link_data_active <= 1'b0;
      calibration_status_pin <= 1'b0;
      sample_data_valid <= 1'b0;
    end else begin
      // R19: code groups until sync released
      link_cgs_active <= link_enable_q && !is_64b && !sync_req;
      link_data_active <= link_enable_q && (is_64b || sync_req);
      // R18: status pin follows done
      calibration_status_pin <= cal.done;
      // R20: valid needs alignment and calibration
      sample_data_valid <= link_enable_q && rx_aligned && cal_ok;
    end
  end

  // R2: clock outputs stop in powerdown
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clock_outputs_enable <= 1'b0;
      trigger_clock_output_enable <= 1'b0;
      overrange_enable <= 1'b0;
    end else begin
      clock_outputs_enable <= !pd_s;
      trigger_clock_output_enable <= !pd_s && trigger_output_control_q[TRIG_OUT_EN_BIT];
      overrange_enable <= overrange_enable_q;
    end
  end

  assign status_word = {24'h000000, sample_data_valid, ref_sel_q, pll_strap_q, cal.busy,
                        cal.done, converter_pll_locked, oscillator_cal_done, init_done_q};

  // read data stand one cycle, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (reg_read) begin
        case (reg_addr)
          ADDR_STATUS: rdata_q <= status_word;
          ADDR_PLL_CTRL: rdata_q <= {8'h00, oscillator_freq_trim_q, oscillator_bias_field_q,
                                     6'h00, oscillator_cal_enable_q, converter_pll_reset_q};
          ADDR_PLL_DIV: rdata_q <= {16'h0000, div_n_q, div_v_q, div_p_q};
          ADDR_LINK_CTRL: rdata_q <= {19'h00000, sync_sel_q, 3'h0, link_mode_select_q,
                                      3'h0, link_enable_q};
          ADDR_KM1: rdata_q <= {24'h000000, multiframe_length_minus_one_q};
          ADDR_CAL_CTRL: rdata_q <= {27'h0000000, overrange_enable_q, cal_status_sel_q,
                                     calibration_pin_trigger_enable_q,
                                     calibration_software_trigger_q, cal_enable_q};
          ADDR_CAL_CFG: rdata_q <= {16'h0000, calibration_config_b_q, calibration_config_a_q};
          ADDR_TRIG_CTRL: rdata_q <= {24'h000000, trigger_output_control_q};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  init_hold_a: assert property (sw_rst_q |=> !init_done_q [*8]) // R5
    else $error("init done raised too soon after reset");
  init_writes_a: assert property (reg_write && !init_done_q && reg_addr == ADDR_LINK_CTRL
                                  && !sw_rst_q |=> $stable(link_enable_q)) // R5
    else $error("write taken before init done");
  link_frozen_a: assert property (wr && link_enable_q && !sw_rst_q |=>
                                  $stable(link_mode_select_q)) // R9
    else $error("link mode changed while link enabled");
  cal_frozen_a: assert property (wr && cal_enable_q && !sw_rst_q |=>
                                 $stable(calibration_config_a_q)) // R10
    else $error("calibration config changed while engine enabled");
  lock_order_a: assert property (converter_pll_locked |-> oscillator_cal_done) // R15
    else $error("lock reported before oscillator calibration");
  lock_drop_a: assert property (converter_pll_reset_q && !cfg_rst |=>
                                !oscillator_cal_done) // R15
    else $error("pll status kept through pll reset");
  bypass_idle_a: assert property (!pll_strap_q |-> pll_state_q == PLL_IN_RESET) // R8
    else $error("bypassed pll left reset");
  soft_start_a: assert property (soft_rise && cal_enable_q && !cal.busy && !sw_rst_q
                                 |=> cal.busy) // R17
    else $error("soft trigger did not start calibration");
  pin_follow_a: assert property (!sw_rst_q && !$past(sw_rst_q) && $rose(cal.done)
                                 |=> calibration_status_pin) // R18
    else $error("status pin did not follow done");
  sync_follow_a: assert property (link_data_active && !$past(is_64b) |->
                                  $past(sync_req)) // R19
    else $error("8b10b data phase without sync");
  valid_cause_a: assert property (sample_data_valid |-> $past(rx_aligned) && $past(cal_ok)) // R20
    else $error("data valid without alignment and calibration");
  read_once_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside read answer cycle");

  init_seen_c: cover property ($rose(init_done_q));
  lock_seen_c: cover property ($rose(converter_pll_locked));
  valid_seen_c: cover property ($rose(sample_data_valid));
  pin_cal_c: cover property (pin_rise && cal_enable_q);
endmodule

// file: adc_startup_sequence_test.sv
`timescale 1ns/1ps
module adc_startup_sequence_test;
  import adc_startup_pkg::*;
  logic sys_clk, rstn, reg_write, reg_read, pll_enable_strap, ref_clock_select_strap;
  logic powerdown_pin, calibration_trigger_pin, sync_q, hdr_lock_q, calibration_status_pin;
  logic link_cgs_active, link_data_active, clock_outputs_enable, trigger_clock_output_enable;
  logic overrange_enable, sample_data_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rnd, lc, s;
  int error_cnt, compares;
  always #5 sys_clk = ~sys_clk;
  adc_startup_sequence #(.INIT_CYC(10), .OSC_CYC(4), .LOCK_CYC(4), .CAL_CYC(8)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pll_enable_strap(pll_enable_strap), .ref_clock_select_strap(ref_clock_select_strap),
    .powerdown_pin(powerdown_pin), .calibration_trigger_pin(calibration_trigger_pin),
    .single_ended_sync_input(sync_q & ~lc[12]), .timestamp_input_pair(sync_q & lc[12]),
    .rx_header_lock(hdr_lock_q), .calibration_status_pin(calibration_status_pin),
    .link_cgs_active(link_cgs_active), .link_data_active(link_data_active),
    .clock_outputs_enable(clock_outputs_enable),
    .trigger_clock_output_enable(trigger_clock_output_enable),
    .overrange_enable(overrange_enable), .sample_data_valid(sample_data_valid));
  rx_model partner (.sys_clk(sys_clk), .rstn(rstn), .link_cgs_active(link_cgs_active),
    .link_data_active(link_data_active), .sync_q(sync_q), .hdr_lock_q(hdr_lock_q));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, s);
    chk($sformatf("reg %h", a), s, e);
  endtask
  task automatic poll(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(ADDR_STATUS, s);
      if (s[b] === 1'b1) return;
    end
    chk("poll", 32'h0, 32'h1);
    print_verdict();
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    lc = 32'h0;
    rnd = 32'h5a46;
    error_cnt = 0;
    compares = 0;
    pll_enable_strap = 1'b1;
    ref_clock_select_strap = 1'b0;
    powerdown_pin = 1'b0;
    calibration_trigger_pin = 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    wr(ADDR_PLL_DIV, 32'h55);
    wr(ADDR_LINK_CTRL, 32'h0);
    rc(ADDR_PLL_DIV, 32'ha42);
    rc(ADDR_PLL_CTRL, 32'h1);
    rc(ADDR_CAL_CTRL, 32'h3);
    rc(8'h24, 32'h0);
    rc(ADDR_LINK_CTRL, 32'h1);
    poll(ST_INIT_DONE_BIT);
    wr(ADDR_PLL_CTRL, 32'h4a01);
    wr(ADDR_PLL_DIV, 32'h0a42);
    wr(ADDR_PLL_CTRL, 32'h4a03);
    wr(ADDR_PLL_CTRL, 32'h4a02);
    poll(ST_PLL_LOCKED_BIT);
    rc(ADDR_STATUS, 32'h27);
    wr(ADDR_KM1, 32'h5);
    rc(ADDR_KM1, 32'h1f);
    wr(ADDR_CAL_CFG, 32'h203);
    rc(ADDR_CAL_CFG, 32'h1);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(ADDR_LINK_CTRL, 32'h0);
      wr(ADDR_CAL_CTRL, 32'h0);
      lc <= {19'h0, i == 1, 3'h0, (i == 2) ? 5'h08 | rnd[2:0] : {2'h0, rnd[2:0]}, 4'h0};
      @(posedge sys_clk);
      wr(ADDR_LINK_CTRL, lc);
      wr(ADDR_KM1, {24'h0, rnd[15:8]});
      wr(ADDR_CAL_CFG, {16'h0, rnd[31:16]});
      wr(ADDR_TRIG_CTRL, 32'h81);
      rc(ADDR_LINK_CTRL, lc);
      rc(ADDR_KM1, {24'h0, rnd[15:8]});
      rc(ADDR_CAL_CFG, {16'h0, rnd[31:16]});
      rc(ADDR_TRIG_CTRL, 32'h81);
      wr(ADDR_CAL_CTRL, 32'h11);
      wr(ADDR_LINK_CTRL, lc | 32'h1);
      settle(3);
      chk("cgs", 32'(link_cgs_active), 32'(i < 2));
      chk("ovr", 32'(overrange_enable), 32'h1);
      chk("trig", 32'(trigger_clock_output_enable), 32'h1);
      chk("clkout", 32'(clock_outputs_enable), 32'h1);
      @(posedge sys_clk);
      wr(ADDR_CAL_CTRL, 32'h13);
      poll(ST_FOREGROUND_CAL_DONE_BIT);
      settle(20);
      chk("calpin", 32'(calibration_status_pin), 32'h1);
      chk("data", 32'(link_data_active), 32'h1);
      chk("valid", 32'(sample_data_valid), 32'h1);
      @(posedge sys_clk);
    end
    wr(ADDR_CAL_CTRL, 32'h17);
    calibration_trigger_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rc(ADDR_STATUS, 32'h37);
    poll(ST_FOREGROUND_CAL_DONE_BIT);
    settle(2);
    chk("calpin", 32'(calibration_status_pin), 32'h1);
    @(posedge sys_clk);
    wr(ADDR_PLL_CTRL, 32'h4a03);
    rc(ADDR_STATUS, 32'ha9);
    powerdown_pin <= 1'b1;
    settle(4);
    chk("clkout", 32'(clock_outputs_enable), 32'h0);
    chk("trigger_clock_output", 32'(trigger_clock_output_enable), 32'h0);
    @(posedge sys_clk);
    powerdown_pin <= 1'b0;
    pll_enable_strap <= 1'b0;
    wr(ADDR_CTRL, 32'h1);
    @(posedge sys_clk);
    rc(ADDR_LINK_CTRL, 32'h1);
    rd(ADDR_STATUS, s);
    chk("init", 32'(s[0]), 32'h0);
    poll(ST_INIT_DONE_BIT);
    wr(ADDR_PLL_CTRL, 32'h4a02);
    repeat (12) @(posedge sys_clk);
    rc(ADDR_STATUS, 32'h1);
    print_verdict();
  end
endmodule

// file: cal_engine.sv
`timescale 1ns/1ps
module cal_engine #(
  parameter int CAL_CYC = adc_startup_pkg::FG_CAL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic cfg_rstn,
  cal_if.engine cal
);
  import adc_startup_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  if (CAL_CYC < 8 || CAL_CYC > 65535) begin : g_chk
    $error("calibration cycle count out of range");
  end

  assign cal.busy = busy_q;
  assign cal.done = done_q;

  // R17: run on trigger
  always_ff @(posedge sys_clk) begin
    if (!cfg_rstn) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (!busy_q) begin
      if (cal.start) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
      end
    end else if (cnt_q == CNT_W'(CAL_CYC - 1)) begin
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // R18: done flag at finish
  always_ff @(posedge sys_clk) begin
    if (!cfg_rstn) begin
      done_q <= 1'b0;
    end else if (busy_q && cnt_q == CNT_W'(CAL_CYC - 1)) begin
      done_q <= 1'b1;
    end else if (cal.start && !busy_q) begin
      done_q <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!cfg_rstn);

  start_runs_a: assert property (cal.start && !busy_q |=> (busy_q && !done_q) [*8]) // R17
    else $error("calibration did not start cleanly");
  finish_done_a: assert property ($fell(busy_q) && $past(cfg_rstn) |-> done_q) // R18
    else $error("calibration finished without done");
  cal_seen_c: cover property ($rose(done_q));
endmodule

// file: cal_if.sv
`timescale 1ns/1ps
interface cal_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport engine (input start, output busy, output done);
endinterface

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_s
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync width must be positive");
  end

  // two flops per pin
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_q <= '0;
      pins_s <= '0;
    end else begin
      meta_q <= pins;
      pins_s <= meta_q;
    end
  end
endmodule

// file: rx_model.sv
`timescale 1ns/1ps
module rx_model #(
  parameter int ALIGN_CYC = 6
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic link_cgs_active,
  input wire logic link_data_active,
  output logic sync_q,
  output logic hdr_lock_q
);
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn || !(link_cgs_active || link_data_active)) begin
      cnt_q <= 4'h0;
      sync_q <= 1'b0;
    end else if (cnt_q == 4'(ALIGN_CYC)) begin
      sync_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    hdr_lock_q <= rstn && link_data_active;
  end
endmodule
